/* trip_clear_restart_pkg.sv */
package trip_clear_restart_pkg;

   // ****************************************************************
   // Register map (word index, byte address is four times this)
   // ****************************************************************
   localparam logic [3:0] REG_CTRL        = 4'h0;
   localparam logic [3:0] REG_WAIT        = 4'h1;
   localparam logic [3:0] REG_FLOOR       = 4'h2;
   localparam logic [3:0] REG_BASE_FREQ   = 4'h3;
   localparam logic [3:0] REG_MAX_FREQ    = 4'h4;
   localparam logic [3:0] REG_SET_FREQ    = 4'h5;
   localparam logic [3:0] REG_ASSIGN_LO   = 4'h6;
   localparam logic [3:0] REG_ASSIGN_HI   = 4'h7;
   localparam logic [3:0] REG_STATUS      = 4'h8;
   localparam logic [3:0] REG_SCAN_CUR    = 4'h9;
   localparam logic [3:0] REG_SCAN_DECEL  = 4'ha;

   // ****************************************************************
   // Field positions of the control word
   // ****************************************************************
   localparam int CTRL_CLR_MODE_LSB  = 0;
   localparam int CTRL_RESTART_LSB   = 2;
   localparam int CTRL_SCAN_SEL_LSB  = 4;

   // ****************************************************************
   // Reset values and clamp limits (wait in 0.1 s, frequencies in 0.01 Hz)
   // ****************************************************************
   localparam logic [9:0]  WAIT_RST       = 10'h00a;
   localparam logic [9:0]  WAIT_MIN       = 10'h003;
   localparam logic [9:0]  WAIT_MAX       = 10'h3e8;
   localparam logic [15:0] FLOOR_RST      = 16'h0000;
   localparam logic [15:0] FLOOR_MAX      = 16'h9c40;
   localparam logic [15:0] BASE_FREQ_RST  = 16'h1388;
   localparam logic [15:0] MAX_FREQ_RST   = 16'h1388;
   localparam logic [15:0] SET_FREQ_RST   = 16'h0000;
   localparam logic [15:0] SCAN_CUR_RST   = 16'h0064;
   localparam logic [15:0] SCAN_DECEL_RST = 16'h0032;
   localparam logic [31:0] ASSIGN_RST     = 32'h0000_0000;

   // ****************************************************************
   // Terminal function codes and timing
   // ****************************************************************
   localparam logic [7:0] FUNC_SWITCHOVER = 8'h0e;
   localparam logic [7:0] FUNC_TRIP_CLEAR = 8'h12;
   localparam int         CLK_KHZ         = 100_000;
   localparam int         WAIT_UNIT_MS    = 100;
   localparam int         WAIT_UNIT_CYC   = WAIT_UNIT_MS * CLK_KHZ;

   // ****************************************************************
   // Modes and states
   // ****************************************************************
   typedef enum logic [1:0] {
      CLR_ON_ASSERT   = 2'h0,
      CLR_ON_RELEASE  = 2'h1,
      CLR_DISABLE     = 2'h2,
      CLR_KEEP_DATA   = 2'h3
   } clear_mode_e;

   typedef enum logic [1:0] {
      START_ZERO  = 2'h0,
      START_MATCH = 2'h1,
      START_SCAN  = 2'h2
   } start_mode_e;

   typedef enum logic [1:0] {
      SCAN_FROM_SHUTOFF = 2'h0,
      SCAN_FROM_MAX     = 2'h1,
      SCAN_FROM_SET     = 2'h2
   } scan_sel_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_SCAN  = 3'b011,
      ST_RUN   = 3'b010,
      ST_HOLD  = 3'b110,
      ST_COAST = 3'b111,
      ST_TRIP  = 3'b101
   } ctrl_state_e;

   typedef struct packed {
      logic [1:0]  clear_mode_select;
      logic [1:0]  post_clear_restart_select;
      logic [1:0]  scan_restart_freq_select;
      logic [9:0]  restart_wait_time;
      logic [15:0] restart_freq_floor;
      logic [15:0] base_freq;
      logic [15:0] max_freq;
      logic [15:0] set_freq;
      logic [63:0] input_terminal_assign;
      logic [15:0] scan_current_level;
      logic [15:0] scan_decel_constant;
   } config_s;

endpackage : trip_clear_restart_pkg

/* trip_clear_restart_control.sv */
module trip_clear_restart_control
   import trip_clear_restart_pkg::*;
#(
   parameter int TERMINALS     = 8,
   parameter int WAIT_UNIT_CYC_P = WAIT_UNIT_CYC
) (
   input  wire logic                  clk_i,
   input  wire logic                  srst_i,
   input  wire logic [3:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [31:0]           avs_writedata_i,
   input  wire logic [3:0]            avs_byteenable_i,
   output logic      [31:0]           avs_readdata_o,
   output logic                       avs_waitrequest_o,
   input  wire logic [TERMINALS-1:0]  terminal_i,
   input  wire logic                  keypad_clear_i,
   input  wire logic                  run_cmd_i,
   input  wire logic                  trip_event_i,
   input  wire logic [15:0]           motor_freq_i,
   input  wire logic [15:0]           output_freq_i,
   input  wire logic                  match_done_i,
   output logic                       output_enable_o,
   output logic                       tripped_o,
   output logic                       start_req_o,
   output logic      [1:0]            start_mode_o,
   output logic      [15:0]           start_freq_o,
   output logic      [15:0]           target_freq_o,
   output logic      [15:0]           scan_current_level_o,
   output logic      [15:0]           scan_decel_constant_o,
   output logic                       thermal_clear_o,
   output logic                       braking_resistor_duty_clear_o
);

   // ****************************************************************
   // State record
   // ****************************************************************
   typedef struct packed {
      ctrl_state_e st;
      logic        pwr_first;
      logic        clr_prev;
      logic        cs_prev;
      logic        key_prev;
      logic [1:0]  mode;
      logic [9:0]  wait_cnt;
      logic [31:0] presc;
      logic [15:0] shutoff_freq;
      config_s     cfg;
      logic        waitreq;
      logic [31:0] rdata;
      logic        out_en;
      logic        tripped;
      logic        start_req;
      logic [15:0] start_freq;
      logic [15:0] target_freq;
      logic        therm_clr;
      logic        brd_clr;
   } state_s;

   state_s s_reg;
   state_s s_next;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // True when any terminal assigned the given code is active
   function automatic logic term_active(input logic [TERMINALS-1:0] t,
                                        input logic [63:0] asg,
                                        input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < TERMINALS; i++) begin
         if (asg[i*8 +: 8] == code && t[i])
            hit = 1'b1;
      end
      return hit;
   endfunction : term_active

   // Byte-lane merge of a write into an existing word
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b])
            r[b*8 +: 8] = wd[b*8 +: 8];
      end
      return r;
   endfunction : be_merge

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   logic        clr_in;
   logic        cs_in;
   logic        clr_rise;
   logic        clr_fall;
   logic        cs_fall;
   logic        key_rise;
   logic        launch;
   logic [1:0]  launch_mode;
   logic        launch_nowait;
   logic        tick;
   logic [31:0] wword;
   logic [31:0] rword;
   logic [15:0] half_base;

   // Terminal decode: plain active-high, no inversion option
   assign clr_in    = term_active(terminal_i, s_reg.cfg.input_terminal_assign,
                                  FUNC_TRIP_CLEAR);
   assign cs_in     = term_active(terminal_i, s_reg.cfg.input_terminal_assign,
                                  FUNC_SWITCHOVER);
   // Edges from consecutive clock samples
   assign clr_rise  = clr_in & ~s_reg.clr_prev;
   assign clr_fall  = ~clr_in & s_reg.clr_prev;
   assign cs_fall   = ~cs_in & s_reg.cs_prev;
   assign key_rise  = keypad_clear_i & ~s_reg.key_prev;
   assign half_base = s_reg.cfg.base_freq >> 1;
   assign tick      = (s_reg.presc == 32'(WAIT_UNIT_CYC_P - 1));

   always_comb begin
      s_next           = s_reg;
      launch           = 1'b0;
      launch_mode      = START_ZERO;
      launch_nowait    = 1'b0;
      wword            = 32'h0000_0000;
      rword            = 32'h0000_0000;
      s_next.clr_prev  = clr_in;
      s_next.cs_prev   = cs_in;
      s_next.key_prev  = keypad_clear_i;
      s_next.pwr_first = 1'b0;
      s_next.start_req = 1'b0;
      s_next.therm_clr = 1'b0;
      s_next.brd_clr   = 1'b0;
      s_next.presc     = tick ? 32'h0000_0000 : s_reg.presc + 32'h0000_0001;

      // Control sequence
      case (s_reg.st)
         ST_IDLE: begin
            if (trip_event_i) begin
               s_next.st = ST_TRIP;
            end else if (s_reg.pwr_first && run_cmd_i &&
                         s_reg.cfg.post_clear_restart_select == START_MATCH) begin
               launch      = 1'b1;
               launch_mode = START_MATCH;
            end else if (run_cmd_i && !cs_in) begin
               launch        = 1'b1;
               launch_nowait = 1'b1;
            end
         end
         ST_RUN: begin
            if (trip_event_i) begin
               s_next.st = ST_TRIP;
               s_next.shutoff_freq = output_freq_i;
            end else if (clr_rise) begin
               // Shutoff or disable while the clear input is held
               s_next.st = ST_HOLD;
               s_next.shutoff_freq = output_freq_i;
               if (s_reg.cfg.clear_mode_select == CLR_ON_ASSERT ||
                   s_reg.cfg.clear_mode_select == CLR_ON_RELEASE) begin
                  // A shutoff here is a full clear and loses protection data
                  s_next.therm_clr = 1'b1;
                  s_next.brd_clr   = 1'b1;
               end
            end else if (cs_in) begin
               s_next.st = ST_COAST;
               s_next.shutoff_freq = output_freq_i;
            end else if (!run_cmd_i) begin
               s_next.st = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (trip_event_i) begin
               s_next.st = ST_TRIP;
            end else if (!clr_in) begin
               if (!run_cmd_i) begin
                  s_next.st = ST_IDLE;
               end else begin
                  launch      = 1'b1;
                  launch_mode = (s_reg.cfg.clear_mode_select == CLR_KEEP_DATA) ?
                                START_ZERO : s_reg.cfg.post_clear_restart_select;
                  launch_nowait = (launch_mode == START_ZERO);
               end
            end
         end
         ST_COAST: begin
            if (trip_event_i) begin
               s_next.st = ST_TRIP;
            end else if (cs_fall && run_cmd_i) begin
               launch      = 1'b1;
               launch_mode = START_MATCH;
            end else if (!cs_in) begin
               s_next.st = ST_IDLE;
            end
         end
         ST_TRIP: begin
            // Output stays off until a clear the mode accepts
            if (key_rise ||
                (s_reg.cfg.clear_mode_select == CLR_ON_RELEASE ? clr_fall
                                                                : clr_rise)) begin
               if (s_reg.cfg.clear_mode_select != CLR_KEEP_DATA) begin
                  s_next.therm_clr = 1'b1;
                  s_next.brd_clr   = 1'b1;
               end
               if (!run_cmd_i) begin
                  s_next.st = ST_IDLE;
               end else begin
                  launch      = 1'b1;
                  launch_mode = (s_reg.cfg.clear_mode_select == CLR_KEEP_DATA) ?
                                START_ZERO : s_reg.cfg.post_clear_restart_select;
                  launch_nowait = (launch_mode == START_ZERO);
               end
            end
         end
         ST_WAIT: begin
            if (trip_event_i) begin
               s_next.st = ST_TRIP;
            end else if (!run_cmd_i) begin
               s_next.st = ST_IDLE;
            end else if (s_reg.wait_cnt != 10'h000) begin
               if (tick)
                  s_next.wait_cnt = s_reg.wait_cnt - 10'h001;
            end else begin
               s_next.start_req = 1'b1;
               case (s_reg.mode)
                  START_MATCH: begin
                     s_next.st = ST_RUN;
                     // Low speed means too little back-EMF to lock on
                     if (motor_freq_i <= s_reg.cfg.restart_freq_floor ||
                         motor_freq_i <= half_base) begin
                        s_next.start_freq = 16'h0000;
                        s_next.mode       = START_ZERO;
                     end else begin
                        s_next.start_freq = motor_freq_i;
                     end
                  end
                  START_SCAN: begin
                     s_next.st = ST_SCAN;
                     case (s_reg.cfg.scan_restart_freq_select)
                        SCAN_FROM_SHUTOFF: s_next.start_freq = s_reg.shutoff_freq;
                        SCAN_FROM_MAX:     s_next.start_freq = s_reg.cfg.max_freq;
                        SCAN_FROM_SET:     s_next.start_freq = s_reg.cfg.set_freq;
                        default:           s_next.start_freq = s_reg.shutoff_freq;
                     endcase
                  end
                  default: begin
                     s_next.st = ST_RUN;
                     s_next.start_freq = 16'h0000;
                  end
               endcase
            end
         end
         ST_SCAN: begin
            // Decelerate at held current until the power stage reports lock
            if (trip_event_i)
               s_next.st = ST_TRIP;
            else if (!run_cmd_i)
               s_next.st = ST_IDLE;
            else if (match_done_i)
               s_next.st = ST_RUN;
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase

      // Common restart launch
      if (launch) begin
         s_next.st          = ST_WAIT;
         s_next.mode        = launch_mode;
         s_next.presc       = 32'h0000_0000;
         s_next.wait_cnt    = launch_nowait ? 10'h000 : s_reg.cfg.restart_wait_time;
         s_next.target_freq = (launch_mode == START_SCAN) ? s_reg.shutoff_freq
                                                          : s_reg.cfg.set_freq;
      end

      s_next.out_en  = (s_next.st == ST_RUN) || (s_next.st == ST_SCAN);
      s_next.tripped = (s_next.st == ST_TRIP);

      // Avalon slave: one wait cycle, then answer
      s_next.waitreq = !((avs_read_i || avs_write_i) && s_reg.waitreq);
      case (avs_address_i)
         REG_CTRL:       rword = {26'h0, s_reg.cfg.scan_restart_freq_select,
                                  s_reg.cfg.post_clear_restart_select,
                                  s_reg.cfg.clear_mode_select};
         REG_WAIT:       rword = {22'h0, s_reg.cfg.restart_wait_time};
         REG_FLOOR:      rword = {16'h0, s_reg.cfg.restart_freq_floor};
         REG_BASE_FREQ:  rword = {16'h0, s_reg.cfg.base_freq};
         REG_MAX_FREQ:   rword = {16'h0, s_reg.cfg.max_freq};
         REG_SET_FREQ:   rword = {16'h0, s_reg.cfg.set_freq};
         REG_ASSIGN_LO:  rword = s_reg.cfg.input_terminal_assign[31:0];
         REG_ASSIGN_HI:  rword = s_reg.cfg.input_terminal_assign[63:32];
         REG_STATUS:     rword = {s_reg.shutoff_freq, 8'h0, 1'b0, s_reg.st,
                                  2'h0, s_reg.out_en, (s_reg.st == ST_TRIP)};
         REG_SCAN_CUR:   rword = {16'h0, s_reg.cfg.scan_current_level};
         REG_SCAN_DECEL: rword = {16'h0, s_reg.cfg.scan_decel_constant};
         default:        rword = 32'h0000_0000;
      endcase
      if (avs_read_i && s_reg.waitreq)
         s_next.rdata = rword;
      wword = be_merge(rword, avs_writedata_i, avs_byteenable_i);
      if (avs_write_i && !s_reg.waitreq) begin
         case (avs_address_i)
            REG_CTRL: begin
               s_next.cfg.clear_mode_select         = wword[CTRL_CLR_MODE_LSB +: 2];
               s_next.cfg.post_clear_restart_select = wword[CTRL_RESTART_LSB +: 2];
               s_next.cfg.scan_restart_freq_select  = wword[CTRL_SCAN_SEL_LSB +: 2];
            end
            REG_WAIT: begin
               // Clamp to the settable range
               if (wword[15:0] > {6'h0, WAIT_MAX})
                  s_next.cfg.restart_wait_time = WAIT_MAX;
               else if (wword[9:0] < WAIT_MIN)
                  s_next.cfg.restart_wait_time = WAIT_MIN;
               else
                  s_next.cfg.restart_wait_time = wword[9:0];
            end
            REG_FLOOR:      s_next.cfg.restart_freq_floor =
                               (wword[15:0] > FLOOR_MAX) ? FLOOR_MAX : wword[15:0];
            REG_BASE_FREQ:  s_next.cfg.base_freq = wword[15:0];
            REG_MAX_FREQ:   s_next.cfg.max_freq = wword[15:0];
            REG_SET_FREQ:   s_next.cfg.set_freq = wword[15:0];
            REG_ASSIGN_LO:  s_next.cfg.input_terminal_assign[31:0] = wword;
            REG_ASSIGN_HI:  s_next.cfg.input_terminal_assign[63:32] = wword;
            REG_SCAN_CUR:   s_next.cfg.scan_current_level = wword[15:0];
            REG_SCAN_DECEL: s_next.cfg.scan_decel_constant = wword[15:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Power-up flag is set by reset for the first cycle only, when the restart select still reads 00, so select 01 never applies at power-up
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_reg                                <= '0;
         s_reg.st                             <= ST_IDLE;
         s_reg.pwr_first                      <= 1'b1;
         s_reg.waitreq                        <= 1'b1;
         s_reg.cfg.restart_wait_time          <= WAIT_RST;
         s_reg.cfg.restart_freq_floor         <= FLOOR_RST;
         s_reg.cfg.base_freq                  <= BASE_FREQ_RST;
         s_reg.cfg.max_freq                   <= MAX_FREQ_RST;
         s_reg.cfg.set_freq                   <= SET_FREQ_RST;
         s_reg.cfg.input_terminal_assign      <= {ASSIGN_RST, ASSIGN_RST};
         s_reg.cfg.scan_current_level         <= SCAN_CUR_RST;
         s_reg.cfg.scan_decel_constant        <= SCAN_DECEL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************************************
   // Outputs, all straight from the state record
   // ****************************************************************
   assign avs_readdata_o                = s_reg.rdata;
   assign avs_waitrequest_o             = s_reg.waitreq;
   assign output_enable_o               = s_reg.out_en;
   assign tripped_o                     = s_reg.tripped;
   assign start_req_o                   = s_reg.start_req;
   assign start_mode_o                  = s_reg.mode;
   assign start_freq_o                  = s_reg.start_freq;
   assign target_freq_o                 = s_reg.target_freq;
   assign scan_current_level_o          = s_reg.cfg.scan_current_level;
   assign scan_decel_constant_o         = s_reg.cfg.scan_decel_constant;
   assign thermal_clear_o               = s_reg.therm_clr;
   assign braking_resistor_duty_clear_o = s_reg.brd_clr;

endmodule : trip_clear_restart_control

/* trip_clear_restart_props.sv */
module trip_clear_restart_props
   import trip_clear_restart_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic        avs_waitrequest_o,
   input wire logic        trip_event_i,
   input wire logic        output_enable_o,
   input wire logic        tripped_o,
   input wire logic        start_req_o,
   input wire logic [1:0]  start_mode_o,
   input wire logic [15:0] start_freq_o,
   input wire logic        thermal_clear_o,
   input wire logic        braking_resistor_duty_clear_o
);
   // *****
   // Trip, restart and bus timing
   // *****
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   a_trip_holds_off: assert property (tripped_o |-> !output_enable_o)
      else $error("output on while tripped");
   a_trip_takes_hold: assert property (trip_event_i && output_enable_o |=> tripped_o)
      else $error("trip event ignored");
   a_trip_has_cause: assert property ($rose(tripped_o) |-> $past(trip_event_i))
      else $error("trip without event");
   a_clear_pair: assert property (thermal_clear_o == braking_resistor_duty_clear_o)
      else $error("counter clears differ");
   a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
   a_bus_release: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_start_drives: assert property (start_req_o |-> output_enable_o && !tripped_o)
      else $error("start without output");
   a_start_pulse: assert property (start_req_o |=> !start_req_o)
      else $error("start longer than a pulse");
   a_zero_start: assert property (start_req_o && start_mode_o == START_ZERO |-> start_freq_o == 16'h0000)
      else $error("zero start at nonzero frequency");
endmodule : trip_clear_restart_props

bind trip_clear_restart_control trip_clear_restart_props u_props (.clk_i, .srst_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .trip_event_i, .output_enable_o, .tripped_o, .start_req_o, .start_mode_o,
   .start_freq_o, .thermal_clear_o, .braking_resistor_duty_clear_o);

/* power_stage_model.sv */
module power_stage_model
   import trip_clear_restart_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        output_enable_i,
   input wire logic [15:0] target_freq_i,
   output logic     [15:0] motor_freq_o = 16'h0000,
   output logic            match_done_o = 1'b0
);
   // Spins up under power, coasts down slowly so a late restart still matches
   always @(posedge clk_i) begin
      if (output_enable_i && motor_freq_o < target_freq_i) begin
         motor_freq_o <= motor_freq_o + 16'h0010;
      end else if (!output_enable_i && motor_freq_o != 16'h0000) begin
         motor_freq_o <= motor_freq_o - 16'h0001;
      end
      match_done_o <= output_enable_i;
   end
endmodule : power_stage_model

/* testbench.sv */
module testbench
   import trip_clear_restart_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, srst_i = 1, rd = 0, wr = 0, key = 0, run = 0, trip = 0;
   logic        waitreq, out_en, tripped, start_req, th_clr, match;
   logic [3:0]  addr = 0;
   logic [7:0]  term = 0;
   logic [31:0] wdata = 0, rdata, q;
   logic [15:0] motor, start_freq, target;
   logic [1:0]  start_mode;
   int          n_mismatch = 0, checks = 0, n_clr = 0, n, c;
   // Wait unit cut to 10 cycles so restarts take tens of cycles
   trip_clear_restart_control #(.WAIT_UNIT_CYC_P(10)) u_trip_clear_restart_control (.clk_i, .srst_i,
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .terminal_i(term),
      .keypad_clear_i(key), .run_cmd_i(run), .trip_event_i(trip), .motor_freq_i(motor),
      .output_freq_i(motor), .match_done_i(match), .output_enable_o(out_en), .tripped_o(tripped),
      .start_req_o(start_req), .start_mode_o(start_mode), .start_freq_o(start_freq),
      .target_freq_o(target), .scan_current_level_o(), .scan_decel_constant_o(),
      .thermal_clear_o(th_clr), .braking_resistor_duty_clear_o());
   power_stage_model u_power_stage_model (.clk_i, .output_enable_i(out_en), .target_freq_i(target),
      .motor_freq_o(motor), .match_done_o(match));
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (th_clr === 1'b1) n_clr++;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk_i); while (waitreq !== 1'b0);
      q = rdata;
      rd <= 0;
      wr <= 0;
   endtask : bus
   task automatic wait_on;
      for (n = 0; out_en !== 1'b1 && n < 200; n++) @(posedge clk_i);
   endtask : wait_on
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (30000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      srst_i <= 0;
      bus(0, REG_WAIT, 0);
      check("wait reset", q, WAIT_RST);
      bus(1, REG_WAIT, 0);
      bus(0, REG_WAIT, 0);
      check("wait clamp", q, WAIT_MIN);
      bus(0, 4'hf, 0);
      check("unmapped", q, 0);
      bus(1, REG_ASSIGN_LO, {16'h0, FUNC_SWITCHOVER, FUNC_TRIP_CLEAR});
      bus(1, REG_SET_FREQ, 32'h2000);
      run <= 1;
      wait_on;
      $display("registers done");
      // Every clear mode; mode 3 is given the matching restart select
      for (int m = 0; m < 4; m++) begin
         bus(1, REG_CTRL, {28'h0, (m == 3) ? 2'h1 : 2'h0, m[1:0]});
         trip <= 1;
         @(posedge clk_i);
         trip <= 0;
         repeat (3) @(posedge clk_i);
         check("tripped", {out_en, tripped}, 2'b01);
         c = n_clr;
         term[0] <= 1;
         repeat (3) @(posedge clk_i);
         check("held", tripped, m == 1);
         term[0] <= 0;
         wait_on;
         if (m < 3) check("no wait", n < 5, 1);
         check("restart", {start_mode, start_freq}, {START_ZERO, 16'h0});
         check("counters", n_clr - c, m != 3);
      end
      trip <= 1;
      @(posedge clk_i);
      trip <= 0;
      key <= 1;
      repeat (4) @(posedge clk_i);
      check("keypad", tripped, 0);
      key <= 0;
      $display("clear modes done");
      // Switchover: matched start, then floor forces zero
      bus(1, REG_CTRL, 0);
      for (int i = 0; i < 2; i++) begin
         bus(1, REG_FLOOR, i ? FLOOR_MAX : 0);
         repeat (600) @(posedge clk_i);
         term[1] <= 1;
         repeat (5) @(posedge clk_i);
         check("coast", out_en, 0);
         term[1] <= 0;
         @(posedge clk_i);
         wait_on;
         check("waited", n > 25, 1);
         check("mode", start_mode, i ? START_ZERO : START_MATCH);
         check("freq", start_freq > 16'h1f00, !i);
      end
      $display("switchover done");
      // Mode 02 with the scan restart select, scan from the shutoff frequency
      bus(1, REG_CTRL, 32'ha);
      term[0] <= 1;
      repeat (3) @(posedge clk_i);
      check("disable", {out_en, tripped}, 2'b00);
      term[0] <= 0;
      wait_on;
      check("scan mode", start_mode, START_SCAN);
      check("scan freq", target, start_freq);
      $display("disable done");
      give_verdict();
   end
endmodule : testbench
